// *** core/suf_pkg.sv ***
// Package for the serial upload stream filter: character codes, buffer
// sizing, flow-control marks, guard timing and shared types.
// Assumes a 100 MHz system clock and a slow fixed-rate timer tick.
package suf_pkg;

  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CHAR_EOF = 8'h1a;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;

  localparam int BUF_DEPTH = 160;
  localparam int FC_HIGH = 128;
  localparam int FC_LOW = 32;

  localparam int CLK_HZ = 100000000;
  localparam int TICK_HZ = 200;
  localparam int GUARD_S = 3;
  localparam int GUARD_TICKS = GUARD_S * TICK_HZ;

  typedef enum logic [1:0] {
    SUF_DEV_CARD,
    SUF_DEV_CON,
    SUF_DEV_CONB
  } suf_dev_t;

  typedef struct packed {
    logic eof;
    logic [7:0] data;
  } suf_entry_t;

endpackage

// *** core/suf_filter.sv ***
// Serial upload stream filter: takes received serial bytes, filters them
// in text or binary upload mode and hands them to a file writer.
// Assumes a byte-wide serial receiver and transmitter outside, a file
// writer with valid/ready, and a tick pulse of one cycle at TICK_HZ.
`timescale 1ns/1ps

// Overview of operation
// - Text mode: each carriage return is written as carriage return plus line feed.
// - Text mode: a line feed already following a carriage return is not doubled.
// - Text mode: XON and XOFF are neither echoed nor written.
// - Text mode: host XOFF pauses our echo (not our XON/XOFF), XON resumes it.
// - Text mode: end-of-file byte closes the file and is not written.
// - Binary mode: every data byte is written unchanged.
// - Binary mode: end-of-file byte inside the guard time is plain data.
// - Binary mode: XON and XOFF are written as data, not acted on, not echoed.
// - Binary mode: end-of-file byte after the guard time closes the file.
// - Binary mode: an end-of-file byte as first byte never ends the upload.
// - Binary mode: the terminating end-of-file byte is not written.
// - Text mode: received file contents are echoed to the host.
// - Send XOFF when we cannot take more, XON when we can again.
// - Buffer received bytes in a 160-byte buffer, dropping bytes when full.
// - Toggle the status indicator as data is written to the card.
// - Console sources are accepted only as source, rejected as destination.
// - Console source takes copy data from the serial receiver.
module suf_filter #(
  parameter int DEPTH = suf_pkg::BUF_DEPTH,
  parameter int HIGH_MARK = suf_pkg::FC_HIGH,
  parameter int LOW_MARK = suf_pkg::FC_LOW,
  parameter int GUARD_TICKS = suf_pkg::GUARD_TICKS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic cmd_valid,
  input wire suf_pkg::suf_dev_t cmd_src,
  input wire suf_pkg::suf_dev_t cmd_dst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic wr_ready,
  input wire logic tx_ready,
  output logic cmd_reject,
  output logic busy,
  output logic serial_src,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic file_close,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic led,
  output logic rx_drop
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int GW = $clog2(GUARD_TICKS + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HIGH_C = CW'(HIGH_MARK);
  localparam logic [CW-1:0] LOW_C = CW'(LOW_MARK);
  localparam logic [GW-1:0] GUARD_C = GW'(GUARD_TICKS);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);
  if (DEPTH < 2 || HIGH_MARK > DEPTH || LOW_MARK >= HIGH_MARK || LOW_MARK < 1) begin : g_chk
    $error("suf_filter: buffer depth or flow-control marks unusable");
  end
  if (GUARD_TICKS < 1) begin : g_chk_guard
    $error("suf_filter: guard tick count must be at least one");
  end
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TEXT,
    ST_BIN
  } suf_state_t;
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  suf_state_t state_q;
  suf_pkg::suf_entry_t buf_q [DEPTH];
  suf_pkg::suf_entry_t head, push_ent;
  logic [PW-1:0] wptr_q, rptr_q;
  logic [CW-1:0] count_q;
  logic [GW-1:0] guard_q;
  logic first_q, eof_seen_q, lf_pend_q, host_paused_q, stopped_q, xoff_req_q, xon_req_q;
  logic echo_pend_q;
  logic [7:0] echo_data_q;
  logic text, bin, start, rx_take, is_flow, push_req, push, pop;
  logic load, do_close, guard_ok, echo_set, wr_stall, want_stop, want_go, tx_free;
  assign text = state_q == ST_TEXT;
  assign bin = state_q == ST_BIN;
  assign start = cmd_valid && state_q == ST_IDLE && cmd_dst == suf_pkg::SUF_DEV_CARD
    && cmd_src != suf_pkg::SUF_DEV_CARD;
  assign rx_take = rx_valid && (text || bin) && !eof_seen_q;
  assign is_flow = rx_data == suf_pkg::CHAR_XON || rx_data == suf_pkg::CHAR_XOFF;
  assign guard_ok = guard_q == '0;
  assign head = buf_q[rptr_q];
  assign wr_stall = wr_valid && !wr_ready;
  assign tx_free = !tx_valid || tx_ready;

  // Classify each received byte before it enters the buffer
  always_comb begin
    push_req = 1'b0;
    push_ent = '{eof: 1'b0, data: rx_data};
    echo_set = 1'b0;
    if (rx_take && text) begin
      if (!is_flow) begin
        push_req = 1'b1;
        if (rx_data == suf_pkg::CHAR_EOF) begin
          push_ent.eof = 1'b1;
        end else begin
          echo_set = 1'b1;
        end
      end
    end else if (rx_take && bin) begin
      push_req = 1'b1;
      if (rx_data == suf_pkg::CHAR_EOF && guard_ok && !first_q) begin
        push_ent.eof = 1'b1;
      end
    end
  end

  assign push = push_req && count_q != DEPTH_C;
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_drop <= 1'b0;
    end else if (clk_en) begin
      rx_drop <= push_req && !push;
    end
  end

  // Drain side: pick the next byte for the writer, inserting line feeds
  always_comb begin
    load = (text || bin) && (!wr_valid || wr_ready);
    pop = 1'b0;
    do_close = 1'b0;
    if (load && lf_pend_q) begin
      if (count_q != '0 && !head.eof && head.data == suf_pkg::CHAR_LF) begin
        pop = 1'b1;
      end
    end else if (load && count_q != '0) begin
      pop = 1'b1;
      do_close = head.eof;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      cmd_reject <= 1'b0;
      serial_src <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      cmd_reject <= cmd_valid && state_q == ST_IDLE && cmd_dst != suf_pkg::SUF_DEV_CARD;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid && cmd_dst == suf_pkg::SUF_DEV_CARD) begin
            serial_src <= cmd_src != suf_pkg::SUF_DEV_CARD;
          end
          if (start && cmd_src == suf_pkg::SUF_DEV_CON) begin
            state_q <= ST_TEXT;
            busy <= 1'b1;
          end else if (start) begin
            state_q <= ST_BIN;
            busy <= 1'b1;
          end
        end
        default: begin
          if (do_close) begin
            state_q <= ST_IDLE;
            busy <= 1'b0;
            serial_src <= 1'b0;
          end
        end
      endcase
    end
  end

  // Receive buffer; storage itself needs no reset
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      buf_q[wptr_q] <= push_ent;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else if (clk_en) begin
      if (start) begin
        wptr_q <= '0;
        rptr_q <= '0;
        count_q <= '0;
      end else begin
        if (push) begin
          wptr_q <= wptr_q == LAST_C ? '0 : wptr_q + 1'b1;
        end
        if (pop) begin
          rptr_q <= rptr_q == LAST_C ? '0 : rptr_q + 1'b1;
        end
        if (push && !pop) begin
          count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  // Writer output register
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      lf_pend_q <= 1'b0;
      file_close <= 1'b0;
    end else if (clk_en) begin
      file_close <= do_close;
      if (start) begin
        lf_pend_q <= 1'b0;
      end else if (load && lf_pend_q && count_q != '0) begin
        wr_valid <= 1'b1;
        wr_data <= suf_pkg::CHAR_LF;
        lf_pend_q <= 1'b0;
      end else if (pop && !do_close) begin
        wr_valid <= 1'b1;
        wr_data <= head.data;
        lf_pend_q <= text && head.data == suf_pkg::CHAR_CR;
      end else if (load) begin
        wr_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      led <= 1'b0;
    end else if (clk_en && wr_valid && wr_ready) begin
      led <= ~led;
    end
  end

  // Guard timer; reloading on every byte makes it measure silence
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      guard_q <= '0;
      first_q <= 1'b1;
      eof_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        guard_q <= GUARD_C;
        first_q <= 1'b1;
        eof_seen_q <= 1'b0;
      end else begin
        if (rx_take) begin
          guard_q <= GUARD_C;
          first_q <= 1'b0;
        end else if (tick && !guard_ok) begin
          guard_q <= guard_q - 1'b1;
        end
        // Bytes after the end marker belong to no file
        if (push && push_ent.eof) begin
          eof_seen_q <= 1'b1;
        end
      end
    end
  end

  // Host flow control applies to text uploads only
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      host_paused_q <= 1'b0;
    end else if (clk_en) begin
      if (!text) begin
        host_paused_q <= 1'b0;
      end else if (rx_take && rx_data == suf_pkg::CHAR_XOFF) begin
        host_paused_q <= 1'b1;
      end else if (rx_take && rx_data == suf_pkg::CHAR_XON) begin
        host_paused_q <= 1'b0;
      end
    end
  end

  // Our own flow control toward the host, with hysteresis
  assign want_stop = count_q >= HIGH_C || (wr_stall && count_q >= LOW_C);
  assign want_go = count_q < LOW_C && !wr_stall;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stopped_q <= 1'b0;
      xoff_req_q <= 1'b0;
      xon_req_q <= 1'b0;
    end else if (clk_en) begin
      if (!(text || bin)) begin
        stopped_q <= 1'b0;
        xoff_req_q <= 1'b0;
        xon_req_q <= 1'b0;
      end else begin
        if (!stopped_q && want_stop) begin
          stopped_q <= 1'b1;
          xoff_req_q <= 1'b1;
          xon_req_q <= 1'b0;
        end else if (stopped_q && want_go) begin
          stopped_q <= 1'b0;
          xon_req_q <= 1'b1;
          xoff_req_q <= 1'b0;
        end else if (tx_free && xoff_req_q) begin
          xoff_req_q <= 1'b0;
        end else if (tx_free && xon_req_q) begin
          xon_req_q <= 1'b0;
        end
      end
    end
  end

  // Echo holding register; a new byte overwrites one not yet sent
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      echo_pend_q <= 1'b0;
      echo_data_q <= 8'h00;
    end else if (clk_en) begin
      if (!text) begin
        echo_pend_q <= 1'b0;
      end else if (echo_set) begin
        echo_pend_q <= 1'b1;
        echo_data_q <= rx_data;
      end else if (tx_free && !xoff_req_q && !xon_req_q && !host_paused_q) begin
        echo_pend_q <= 1'b0;
      end
    end
  end

  // Transmitter: flow characters first, then echo unless the host paused us
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (clk_en && tx_free) begin
      if (xoff_req_q) begin
        tx_valid <= 1'b1;
        tx_data <= suf_pkg::CHAR_XOFF;
      end else if (xon_req_q) begin
        tx_valid <= 1'b1;
        tx_data <= suf_pkg::CHAR_XON;
      end else if (echo_pend_q && !host_paused_q && text) begin
        tx_valid <= 1'b1;
        tx_data <= echo_data_q;
      end else begin
        tx_valid <= 1'b0;
      end
    end
  end

endmodule // suf_filter

// *** test/suf_filter_sva.sv ***
// Checker for the upload filter: handshakes, mode filtering, commands, indicator.
// Assumes it is bound into suf_filter and sees only that module's ports.
`timescale 1ns/1ps
module suf_filter_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire suf_pkg::suf_dev_t cmd_src,
  input wire suf_pkg::suf_dev_t cmd_dst,
  input wire logic wr_ready,
  input wire logic tx_ready,
  input wire logic cmd_reject,
  input wire logic busy,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic file_close,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic led
);
  logic bin_q;
  logic take;
  logic acc;
  assign take = cmd_valid && clk_en && !busy;
  assign acc = wr_valid && wr_ready && clk_en;
  // Mode of the running upload, needed to tell text from binary rules
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      bin_q <= 1'b0;
    else if (take)
      bin_q <= cmd_src == suf_pkg::SUF_DEV_CONB;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("writer byte dropped before ready");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit byte changed before ready");
  led_track_a: assert property (clk_en |=> (led ^ $past(led)) == $past(acc))
    else $error("indicator not toggling with written bytes");
  dst_reject_a: assert property (take && cmd_dst != suf_pkg::SUF_DEV_CARD |=> cmd_reject && !busy)
    else $error("console destination not rejected");
  con_accept_a: assert property (take && cmd_dst == suf_pkg::SUF_DEV_CARD
    && cmd_src != suf_pkg::SUF_DEV_CARD |=> busy && !cmd_reject)
    else $error("console source copy not started");
  text_strip_a: assert property (busy && !bin_q && wr_valid |-> wr_data != suf_pkg::CHAR_XON
    && wr_data != suf_pkg::CHAR_XOFF && wr_data != suf_pkg::CHAR_EOF)
    else $error("control byte written in text mode");
  bin_no_echo_a: assert property (busy && bin_q && tx_valid |-> tx_data == suf_pkg::CHAR_XON
    || tx_data == suf_pkg::CHAR_XOFF)
    else $error("echo sent in binary mode");
  close_idle_a: assert property (file_close |=> !busy && !file_close)
    else $error("upload still busy after close");
  cover property (file_close && bin_q);
  cover property (cmd_reject);
  cover property (wr_valid && !wr_ready);
endmodule // suf_filter_sva

bind suf_filter suf_filter_sva chk_i (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
  .cmd_valid(cmd_valid), .cmd_src(cmd_src), .cmd_dst(cmd_dst), .wr_ready(wr_ready),
  .tx_ready(tx_ready), .cmd_reject(cmd_reject), .busy(busy), .wr_valid(wr_valid),
  .wr_data(wr_data), .file_close(file_close), .tx_valid(tx_valid), .tx_data(tx_data),
  .led(led));

// *** test/suf_host.sv ***
// Host terminal model: sends bytes to the receiver and takes transmitted bytes.
// Assumes one clock; drives its outputs on the falling edge.
`timescale 1ns/1ps
module suf_host (
  input wire logic ref_clk,
  input wire logic flow_on,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] echo[$];
  logic [7:0] fc[$];
  logic paused;
  int n;
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    paused = 1'b0;
    n = 0;
  end
  // Slow mode takes a byte only every fourth cycle
  always @(negedge ref_clk) begin
    n <= n + 1;
    tx_ready <= !slow || (n % 4 == 0);
  end
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      if (tx_data == 8'h13 || tx_data == 8'h11)
        fc.push_back(tx_data);
      else
        echo.push_back(tx_data);
      if (tx_data == 8'h13)
        paused <= 1'b1;
      if (tx_data == 8'h11)
        paused <= 1'b0;
    end
  end
  task automatic send(input logic [7:0] b);
    // A hang here is caught by the bench's cycle ceiling
    while (flow_on && paused) @(negedge ref_clk);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    // Released line shows the inverse, never a stale copy
    rx_data = ~b;
  endtask
endmodule // suf_host

// *** test/tb.sv ***
// Testbench for the upload filter: rejects, text, binary and overflow uploads.
// Assumes the checker is bound in; the guard is shortened to 4 ticks of 8 cycles.
`timescale 1ns/1ps
module tb;
  logic ref_clk, arst_n, clk_en, tick, cmd_valid, wr_ready, flow_on, slow;
  suf_pkg::suf_dev_t cmd_src, cmd_dst;
  logic cmd_reject, busy, serial_src, wr_valid, file_close, tx_valid, led, rx_drop;
  logic rx_valid, tx_ready;
  logic [7:0] wr_data, tx_data, rx_data;
  logic [7:0] wq[$];
  int num_errors, check_count, cyc, drops, closes;
  suf_filter #(.GUARD_TICKS(4)) u_suf_filter (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(clk_en), .tick(tick), .cmd_valid(cmd_valid), .cmd_src(cmd_src),
    .cmd_dst(cmd_dst), .rx_valid(rx_valid), .rx_data(rx_data), .wr_ready(wr_ready),
    .tx_ready(tx_ready), .cmd_reject(cmd_reject), .busy(busy), .serial_src(serial_src),
    .wr_valid(wr_valid), .wr_data(wr_data), .file_close(file_close), .tx_valid(tx_valid),
    .tx_data(tx_data), .led(led), .rx_drop(rx_drop));
  suf_host host_m (.ref_clk(ref_clk), .flow_on(flow_on), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) tick <= (cyc % 8 == 7);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (wr_valid && wr_ready)
      wq.push_back(wr_data);
    if (rx_drop)
      drops++;
    if (file_close)
      closes++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk_q(input logic [7:0] e[$]);
    check(16'(wq.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, wq[i]}, {8'h00, e[i]});
  endtask
  task automatic cmd(input suf_pkg::suf_dev_t s, input suf_pkg::suf_dev_t d);
    @(negedge ref_clk);
    cmd_src = s;
    cmd_dst = d;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_idle();
    while (busy !== 1'b0) @(negedge ref_clk);
    // The close pulse is counted one edge after busy falls
    @(negedge ref_clk);
  endtask
  task automatic t_reject();
    // Frozen by the clock enable, a valid command must leave no trace
    clk_en = 1'b0;
    cmd(suf_pkg::SUF_DEV_CON, suf_pkg::SUF_DEV_CARD);
    check({cmd_reject, busy}, 16'h0);
    clk_en = 1'b1;
    cmd(suf_pkg::SUF_DEV_CARD, suf_pkg::SUF_DEV_CON);
    check({cmd_reject, busy}, 16'h2);
    cmd(suf_pkg::SUF_DEV_CON, suf_pkg::SUF_DEV_CONB);
    check({cmd_reject, busy}, 16'h2);
  endtask
  task automatic t_text();
    logic [7:0] s[$];
    s = {8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a, 8'h11, 8'h13, 8'h43};
    cmd(suf_pkg::SUF_DEV_CON, suf_pkg::SUF_DEV_CARD);
    check({busy, serial_src}, 16'h3);
    wq = {};
    host_m.echo = {};
    foreach (s[i]) host_m.send(s[i]);
    repeat (20) @(negedge ref_clk);
    check(16'(host_m.echo.size()), 16'd5);
    host_m.send(8'h11);
    repeat (20) @(negedge ref_clk);
    check({8'h00, host_m.echo[5]}, 16'h43);
    host_m.send(8'h1a);
    wait_idle();
    chk_q({8'h41, 8'h0d, 8'h0a, 8'h42, 8'h0d, 8'h0a, 8'h43});
    check(16'(closes), 16'd1);
  endtask
  task automatic t_bin();
    logic [7:0] s[$];
    s = {8'h1a, 8'h11, 8'h13, 8'h0d, 8'h1a};
    cmd(suf_pkg::SUF_DEV_CONB, suf_pkg::SUF_DEV_CARD);
    wq = {};
    host_m.echo = {};
    foreach (s[i]) host_m.send(s[i]);
    // Longer than the shortened guard, whatever the tick phase
    repeat (60) @(negedge ref_clk);
    host_m.send(8'h1a);
    wait_idle();
    chk_q(s);
    check(16'(host_m.echo.size()), 16'd0);
    check(16'(closes), 16'd2);
  endtask
  task automatic t_fill();
    wr_ready = 1'b0;
    flow_on = 1'b0;
    slow = 1'b1;
    cmd(suf_pkg::SUF_DEV_CONB, suf_pkg::SUF_DEV_CARD);
    wq = {};
    host_m.fc = {};
    for (int i = 0; i < 170; i++) host_m.send(8'(i));
    check(16'(drops > 0), 16'd1);
    check({8'h00, host_m.fc[0]}, 16'h13);
    wr_ready = 1'b1;
    repeat (400) @(negedge ref_clk);
    check(16'(wq.size() + drops), 16'd170);
    check({8'h00, host_m.fc[$]}, 16'h11);
    repeat (60) @(negedge ref_clk);
    host_m.send(8'h1a);
    wait_idle();
    check(16'(closes), 16'd3);
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    tick = 1'b0;
    cmd_valid = 1'b0;
    cmd_src = suf_pkg::SUF_DEV_CARD;
    cmd_dst = suf_pkg::SUF_DEV_CARD;
    wr_ready = 1'b1;
    flow_on = 1'b1;
    slow = 1'b0;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    drops = 0;
    closes = 0;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reject();
    t_text();
    t_bin();
    t_fill();
    end_sim();
  end
endmodule // tb
